/* File: common/bol_pkg.sv */
package bol_pkg;

  // ----------------------------------------------------------------
  // Sizes and per-use limits
  // ----------------------------------------------------------------
  localparam int NUM_GPIO = 22;
  localparam int NUM_AUX = 4;
  localparam int NUM_PINS = 26;
  localparam int NUM_FAST = 8;
  localparam int NUM_SLOTS = 12;
  localparam int NUM_RAILS = 12;
  localparam int NUM_GIN = 8;
  localparam int NUM_FB = 8;
  localparam int NUM_TYPES = 17;
  localparam int MAX_RAIL_EN = 12;
  localparam int MAX_GIN = 8;
  localparam int MAX_GPO = 12;
  localparam int MAX_PWM = 12;
  localparam int MAX_MPWM = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DLY_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_BASE = 8'h00;
  localparam logic [7:0] PIN_STAT = 8'h30;
  localparam logic [7:0] RESULT = 8'h31;
  localparam logic [7:0] CFG_ERR = 8'h32;
  localparam logic [7:0] LATCH_CLR = 8'h33;
  localparam logic [7:0] CLR_SEL = 8'h34;
  localparam logic [7:0] SLOT_BASE = 8'h40;
  localparam logic [7:0] SLOT_END = 8'hA0;
  localparam logic [2:0] SLOT_CTRL = 3'h0;
  localparam logic [2:0] SLOT_T0 = 3'h1;
  localparam logic [2:0] SLOT_R0 = 3'h2;
  localparam logic [2:0] SLOT_T1 = 3'h3;
  localparam logic [2:0] SLOT_R1 = 3'h4;
  localparam logic [2:0] SLOT_DA = 3'h5;
  localparam logic [2:0] SLOT_DD = 3'h6;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    USE_NONE = 3'h0, USE_INPUT = 3'h1, USE_OUTPUT = 3'h2,
    USE_RAIL_EN = 3'h3, USE_PWM = 3'h4, USE_MPWM = 3'h5
  } bol_use_e;

  typedef enum logic [1:0] {
    SRC_OFF = 2'h0, SRC_HOST = 2'h1, SRC_LOGIC = 2'h2, SRC_RAIL = 2'h3
  } bol_src_e;

  typedef struct packed {
    logic pol_high;
    logic open_drain;
    bol_use_e use_sel;
  } bol_pin_s;

  typedef struct packed {
    logic [3:0] rail;
    logic state_mach;
    logic hold_off;
    logic dly_deassert;
    logic dly_assert;
    logic host_val;
    bol_src_e src;
    logic [4:0] pin;
  } bol_ctrl_s;

  typedef struct packed {
    logic [11:0] rail_m;
    logic latched;
    logic [4:0] stype;
    logic [7:0] in_m;
    logic [7:0] out_m;
  } bol_term_s;

  localparam bol_pin_s PIN_RST = 5'h00;
  localparam bol_ctrl_s CTRL_RST = 16'h0000;
  localparam bol_term_s TERM_RST = 34'h0_0000_0000;

endpackage

/* File: verilog/bol_delay.sv */
`timescale 1ns/10ps
`default_nettype none

module bol_delay #(
  parameter int DLY_W = bol_pkg::DLY_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Timebase and source
  input wire logic tick,
  input wire logic target,
  // Configuration
  input wire logic en_a,
  input wire logic en_d,
  input wire logic hold,
  input wire logic [DLY_W-1:0] load_a,
  input wire logic [DLY_W-1:0] load_d,
  // Delayed level
  output logic level
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_GUARD = 3'b100
  } bol_dly_e;

  bol_dly_e st_q, st_d;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic pend_q, pend_d, lvl_q, lvl_d;

  wire want = target ? en_a : en_d;
  wire [DLY_W-1:0] load_new = target ? load_a : load_d;
  wire [DLY_W-1:0] load_used = pend_q ? load_a : load_d;
  wire back_fast = pend_q ? ~en_d : ~en_a;
  wire last = tick && (cnt_q == {{(DLY_W-1){1'b0}}, 1'b1});

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    lvl_d = lvl_q;
    case (st_q)
      ST_IDLE: begin
        if (target != lvl_q) begin
          if (want && load_new != '0) begin
            st_d = ST_WAIT;
            cnt_d = load_new;
            pend_d = target;
          end else begin
            lvl_d = target;
          end
        end
      end
      ST_WAIT: begin
        if (!hold && target != pend_q) begin
          st_d = ST_IDLE;
        end else if (last) begin
          lvl_d = pend_q;
          // Undelayed return edge would cut the pulse short
          if (hold && back_fast) begin
            st_d = ST_GUARD;
            cnt_d = load_used;
          end else begin
            st_d = ST_IDLE;
          end
        end else if (tick) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_GUARD: begin
        if (last) begin
          st_d = ST_IDLE;
        end else if (tick) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      pend_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule

`default_nettype wire

/* File: verilog/bol_top.sv */
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module bol_top #(
  parameter int NUM_SLOTS = bol_pkg::NUM_SLOTS,
  parameter int DLY_W = bol_pkg::DLY_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // General pins
  input wire logic [21:0] gpio_in,
  output logic [21:0] gpio_out,
  output logic [21:0] gpio_oe,
  // Input or PWM-only pins
  input wire logic [3:0] aux_in,
  output logic [3:0] aux_out,
  output logic [3:0] aux_oe,
  // PWM generator levels, one per pin
  input wire logic [25:0] fast_pulse_output,
  // Sequencer side
  input wire logic [11:0] rail_enable,
  input wire logic [16:0][11:0] rail_status,
  output logic [25:0] pin_state
);

  // ----------------------------------------------------------------
  // Pin inputs and timebase
  // ----------------------------------------------------------------
  localparam int NP = bol_pkg::NUM_PINS;
  localparam logic [7:0] TICK_LAST = 8'(bol_pkg::TICK_CYC - 1);

  logic [NP-1:0] meta_q, sync_q;
  logic [7:0] tick_q;
  wire tick = (tick_q == TICK_LAST);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      tick_q <= 8'h00;
    end else begin
      meta_q <= {aux_in, gpio_in};
      sync_q <= meta_q;
      tick_q <= tick ? 8'h00 : tick_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  bol_pkg::bol_pin_s pin_q [NP];
  bol_pkg::bol_ctrl_s ctrl_q [NUM_SLOTS];
  bol_pkg::bol_term_s term_q [NUM_SLOTS][2];
  logic [DLY_W-1:0] dly_a_q [NUM_SLOTS];
  logic [DLY_W-1:0] dly_d_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] result_q, slot_lvl;
  logic [16:0][11:0] latch_q;
  logic [5:0] clr_sel_q;
  logic cfg_err_q;
  logic [NP-1:0] pin_out_q, pin_oe_q, pin_state_q;
  logic [31:0] rdata_q;

  wire pin_hit = reg_addr < 8'(NP);
  wire [4:0] pin_idx = reg_addr[4:0];
  wire slot_hit = reg_addr >= bol_pkg::SLOT_BASE &&
                  reg_addr < bol_pkg::SLOT_END;
  wire [7:0] slot_off = reg_addr - bol_pkg::SLOT_BASE;
  wire [3:0] slot_idx = slot_off[6:3];
  wire [2:0] slot_reg = reg_addr[2:0];
  wire vendor_clr = reg_wr && reg_addr == bol_pkg::LATCH_CLR &&
                    reg_wdata[0];
  wire err_clr = reg_wr && reg_addr == bol_pkg::CFG_ERR && reg_wdata[0];
  wire bol_pkg::bol_pin_s new_pin = reg_wdata[4:0];

  // ----------------------------------------------------------------
  // Pin setup checking
  // ----------------------------------------------------------------
  logic pin_bad;

  always_comb begin
    bol_pkg::bol_pin_s c;
    int n_rail, n_gin, n_gpo, n_pwm, n_mpwm;
    c = bol_pkg::PIN_RST;
    n_rail = 0;
    n_gin = 0;
    n_gpo = 0;
    n_pwm = 0;
    n_mpwm = 0;
    for (int p = 0; p < NP; p++) begin
      c = (p == int'(pin_idx)) ? new_pin : pin_q[p];
      n_rail += int'(c.use_sel == bol_pkg::USE_RAIL_EN);
      n_gin += int'(c.use_sel == bol_pkg::USE_INPUT);
      n_gpo += int'(c.use_sel == bol_pkg::USE_OUTPUT);
      n_pwm += int'(c.use_sel == bol_pkg::USE_PWM ||
                    c.use_sel == bol_pkg::USE_MPWM);
      n_mpwm += int'(c.use_sel == bol_pkg::USE_MPWM);
    end
    pin_bad = n_rail > bol_pkg::MAX_RAIL_EN || n_gin > bol_pkg::MAX_GIN ||
              n_gpo > bol_pkg::MAX_GPO || n_pwm > bol_pkg::MAX_PWM ||
              n_mpwm > bol_pkg::MAX_MPWM;
    if (int'(pin_idx) >= bol_pkg::NUM_GPIO) begin
      // Aux pins: inputs or PWM only, margin PWM on the upper two
      if (new_pin.use_sel == bol_pkg::USE_OUTPUT ||
          new_pin.use_sel == bol_pkg::USE_RAIL_EN ||
          new_pin.use_sel > bol_pkg::USE_MPWM ||
          (new_pin.use_sel == bol_pkg::USE_MPWM &&
           int'(pin_idx) < bol_pkg::NUM_GPIO + 2)) begin
        pin_bad = 1'b1;
      end
    end else if ((new_pin.use_sel == bol_pkg::USE_PWM ||
                  new_pin.use_sel == bol_pkg::USE_MPWM) &&
                 int'(pin_idx) >= bol_pkg::NUM_FAST) begin
      pin_bad = 1'b1;
    end else if (new_pin.use_sel > bol_pkg::USE_MPWM) begin
      pin_bad = 1'b1;
    end
  end

  wire pin_wr = reg_wr && pin_hit;

  // ----------------------------------------------------------------
  // General inputs in definition order
  // ----------------------------------------------------------------
  logic [7:0] gin;

  always_comb begin
    int n;
    n = 0;
    gin = 8'h00;
    for (int p = 0; p < NP; p++) begin
      if (pin_q[p].use_sel == bol_pkg::USE_INPUT && n < bol_pkg::NUM_GIN)
      begin
        gin[n[2:0]] = pin_q[p].pol_high ? sync_q[p] : ~sync_q[p];
        n++;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and status storage
  // ----------------------------------------------------------------
  wire gin_clr = clr_sel_q[5] && gin[clr_sel_q[2:0]];
  wire latch_clr = vendor_clr | gin_clr;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_err_q <= 1'b0;
      clr_sel_q <= 6'h00;
      latch_q <= '0;
    end else begin
      // A new rejection in the clearing cycle still shows
      cfg_err_q <= (pin_wr && pin_bad) | (cfg_err_q & ~err_clr);
      if (reg_wr && reg_addr == bol_pkg::CLR_SEL) begin
        clr_sel_q <= reg_wdata[5:0];
      end
      latch_q <= rail_status | (latch_q & ~{17 * 12{latch_clr}});
    end
  end

  generate
    for (genvar p = 0; p < NP; p++) begin : g_pin
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pin_q[p] <= bol_pkg::PIN_RST;
        end else if (pin_wr && !pin_bad && int'(pin_idx) == p) begin
          pin_q[p] <= new_pin;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Logic blocks and delays, one per output slot
  // ----------------------------------------------------------------
  wire [7:0] fb = slot_lvl[7:0];

  function automatic logic term_hit(bol_pkg::bol_term_s t,
                                    logic [7:0] f, logic [7:0] g,
                                    logic [16:0][11:0] live,
                                    logic [16:0][11:0] held);
    logic [11:0] flags;
    flags = 12'h000;
    if (int'(t.stype) < bol_pkg::NUM_TYPES) begin
      flags = t.latched ? held[t.stype] : live[t.stype];
    end
    term_hit = (|{t.out_m, t.in_m, t.rail_m}) && &(f | ~t.out_m) &&
               &(g | ~t.in_m) && &(flags | ~t.rail_m);
  endfunction

  generate
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      wire wr_s = reg_wr && slot_hit && int'(slot_idx) == s;
      wire h0 = term_hit(term_q[s][0], fb, gin, rail_status, latch_q);
      wire h1 = term_hit(term_q[s][1], fb, gin, rail_status, latch_q);
      wire sm_next = result_q[s] ? h0 : h1;
      wire logic_next = ctrl_q[s].state_mach ? sm_next : (h0 | h1);
      logic src_val;

      always_comb begin
        case (ctrl_q[s].src)
          bol_pkg::SRC_HOST: src_val = ctrl_q[s].host_val;
          bol_pkg::SRC_LOGIC: src_val = result_q[s];
          bol_pkg::SRC_RAIL: src_val = rail_enable[ctrl_q[s].rail];
          default: src_val = 1'b0;
        endcase
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          ctrl_q[s] <= bol_pkg::CTRL_RST;
          term_q[s][0] <= bol_pkg::TERM_RST;
          term_q[s][1] <= bol_pkg::TERM_RST;
          dly_a_q[s] <= '0;
          dly_d_q[s] <= '0;
          result_q[s] <= 1'b0;
        end else begin
          result_q[s] <= (ctrl_q[s].src == bol_pkg::SRC_LOGIC) & logic_next;
          if (wr_s && slot_reg == bol_pkg::SLOT_CTRL) begin
            ctrl_q[s] <= reg_wdata[15:0];
          end
          if (wr_s && slot_reg == bol_pkg::SLOT_T0) begin
            term_q[s][0][21:0] <= reg_wdata[21:0];
          end
          if (wr_s && slot_reg == bol_pkg::SLOT_R0) begin
            term_q[s][0].rail_m <= reg_wdata[11:0];
          end
          if (wr_s && slot_reg == bol_pkg::SLOT_T1) begin
            term_q[s][1][21:0] <= reg_wdata[21:0];
          end
          if (wr_s && slot_reg == bol_pkg::SLOT_R1) begin
            term_q[s][1].rail_m <= reg_wdata[11:0];
          end
          if (wr_s && slot_reg == bol_pkg::SLOT_DA) begin
            dly_a_q[s] <= reg_wdata[DLY_W-1:0];
          end
          if (wr_s && slot_reg == bol_pkg::SLOT_DD) begin
            dly_d_q[s] <= reg_wdata[DLY_W-1:0];
          end
        end
      end

      bol_delay #(
        .DLY_W(DLY_W)
      ) u_delay (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick),
        .target(src_val),
        .en_a(ctrl_q[s].dly_assert),
        .en_d(ctrl_q[s].dly_deassert),
        .hold(ctrl_q[s].hold_off),
        .load_a(dly_a_q[s]),
        .load_d(dly_d_q[s]),
        .level(slot_lvl[s])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < NP; p++) begin : g_drv
      logic val, owned, out_d, oe_d;
      always_comb begin
        val = 1'b0;
        owned = 1'b0;
        for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
          if (ctrl_q[s].src != bol_pkg::SRC_OFF &&
              int'(ctrl_q[s].pin) == p) begin
            val = slot_lvl[s];
            owned = 1'b1;
          end
        end
        out_d = 1'b0;
        oe_d = 1'b0;
        case (pin_q[p].use_sel)
          bol_pkg::USE_OUTPUT, bol_pkg::USE_RAIL_EN: begin
            if (owned && p < bol_pkg::NUM_GPIO) begin
              out_d = pin_q[p].open_drain ? 1'b0 : val;
              oe_d = pin_q[p].open_drain ? ~val : 1'b1;
            end
          end
          bol_pkg::USE_PWM, bol_pkg::USE_MPWM: begin
            out_d = fast_pulse_output[p];
            oe_d = 1'b1;
          end
          default: begin
            out_d = 1'b0;
            oe_d = 1'b0;
          end
        endcase
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pin_out_q[p] <= 1'b0;
          pin_oe_q[p] <= 1'b0;
          pin_state_q[p] <= 1'b0;
        end else begin
          pin_out_q[p] <= out_d;
          pin_oe_q[p] <= oe_d;
          pin_state_q[p] <= oe_d ? out_d :
                            (pin_q[p].pol_high ? sync_q[p] : ~sync_q[p]);
        end
      end
    end
  endgenerate

  assign gpio_out = pin_out_q[21:0];
  assign gpio_oe = pin_oe_q[21:0];
  assign aux_out = pin_out_q[25:22];
  assign aux_oe = pin_oe_q[25:22];
  assign pin_state = pin_state_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (pin_hit) begin
      rd_val = {27'h000_0000, pin_q[pin_idx]};
    end else if (slot_hit) begin
      case (slot_reg)
        bol_pkg::SLOT_CTRL: rd_val = {16'h0000, ctrl_q[slot_idx]};
        bol_pkg::SLOT_T0: rd_val = {10'h000, term_q[slot_idx][0][21:0]};
        bol_pkg::SLOT_R0: rd_val = {20'h00000, term_q[slot_idx][0].rail_m};
        bol_pkg::SLOT_T1: rd_val = {10'h000, term_q[slot_idx][1][21:0]};
        bol_pkg::SLOT_R1: rd_val = {20'h00000, term_q[slot_idx][1].rail_m};
        bol_pkg::SLOT_DA: rd_val = 32'(dly_a_q[slot_idx]);
        bol_pkg::SLOT_DD: rd_val = 32'(dly_d_q[slot_idx]);
        default: rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (reg_addr)
        bol_pkg::PIN_STAT: rd_val = {6'h00, pin_state_q};
        bol_pkg::RESULT: rd_val = {8'h00, slot_lvl[3:0], 16'h0000,
                                   result_q[3:0]};
        bol_pkg::CFG_ERR: rd_val = {31'h0000_0000, cfg_err_q};
        bol_pkg::CLR_SEL: rd_val = {26'h000_0000, clr_sel_q};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

/* File: tb/bol_load_model.sv */
`timescale 1ns/10ps
`default_nettype none

module bol_load_model (
  // Device side of the pins
  input wire logic [21:0] gpio_out,
  input wire logic [21:0] gpio_oe,
  input wire logic [3:0] aux_out,
  input wire logic [3:0] aux_oe,
  // Levels the external loads apply
  input wire logic [21:0] ext,
  input wire logic [3:0] aux_ext,
  // Resolved wires
  output logic [21:0] gpio_in,
  output logic [3:0] aux_in
);
  // Device drive wins; a released pin shows only what the load applies
  assign gpio_in = (gpio_out & gpio_oe) | (ext & ~gpio_oe);
  assign aux_in = (aux_out & aux_oe) | (aux_ext & ~aux_oe);
endmodule

`default_nettype wire

/* File: tb/bol_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module bol_monitor #(
  parameter int NUM_SLOTS = 12,
  parameter int DLY_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins
  input wire logic [21:0] gpio_in,
  input wire logic [21:0] gpio_out,
  input wire logic [21:0] gpio_oe,
  input wire logic [3:0] aux_in,
  input wire logic [3:0] aux_out,
  input wire logic [3:0] aux_oe,
  input wire logic [25:0] fast_pulse_output,
  // Sequencer side
  input wire logic [11:0] rail_enable,
  input wire logic [16:0][11:0] rail_status,
  input wire logic [25:0] pin_state
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_rdata_one_cycle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0
  ) else $error("read data outside its cycle");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> gpio_oe == 22'h0 && aux_oe == 4'h0 ##1
      gpio_oe == 22'h0 && aux_oe == 4'h0
  ) else $error("pin driven right after reset");
  a_pin_state_drv: assert property (
    ($stable(gpio_out) && $stable(gpio_oe)) [*2] |->
      ((pin_state[21:0] ^ gpio_out) & gpio_oe) == 22'h0
  ) else $error("pin state differs from driven value");
  a_aux_state_drv: assert property (
    ($stable(aux_out) && $stable(aux_oe)) [*2] |->
      ((pin_state[25:22] ^ aux_out) & aux_oe) == 4'h0
  ) else $error("aux pin state differs from driven value");
  a_aux_pwm_follow: assert property (
    ($stable(fast_pulse_output) && $stable(aux_oe)) [*3] |->
      ((aux_out ^ fast_pulse_output[25:22]) & aux_oe) == 4'h0
  ) else $error("aux pin drives something other than PWM");
  a_state_readback: assert property (
    reg_rd && reg_addr == 8'h30 |=> reg_rdata[25:0] == $past(pin_state)
  ) else $error("pin state read back wrong");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr >= 8'hA0 |=> reg_rdata == 32'h0
  ) else $error("unmapped read not zero");
  a_clear_sel_back: assert property (
    reg_wr && reg_addr == 8'h34 ##1 reg_rd && reg_addr == 8'h34 |=>
      (reg_rdata & 32'h27) == ($past(reg_wdata, 2) & 32'h27)
  ) else $error("clear input select read back wrong");
endmodule

bind bol_top bol_monitor #(
  .NUM_SLOTS(NUM_SLOTS),
  .DLY_W(DLY_W)
) u_monitor (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .aux_in(aux_in), .aux_out(aux_out),
  .aux_oe(aux_oe), .fast_pulse_output(fast_pulse_output),
  .rail_enable(rail_enable), .rail_status(rail_status),
  .pin_state(pin_state)
);

`default_nettype wire

/* File: tb/bol_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module bol_top_tb_top;
  logic mclk, rst_n, reg_wr, reg_rd, rd_d, cnt_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [21:0] gpio_in, gpio_out, gpio_oe, ext;
  logic [3:0] aux_in, aux_out, aux_oe;
  logic [25:0] fast_pulse_output, pin_state;
  logic [11:0] rail_enable;
  logic [16:0][11:0] rail_status;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [2:0] cyc;
  logic [4:0] st;
  // Step: input level, status a, status b, expected pin 1, pin 5
  logic [4:0] stp [5] = '{5'h1B, 5'h13, 5'h06, 5'h12, 5'h00};
  int seed = 32'h1C4F;
  int miscompares = 0, comparisons = 0, hi3 = 0, hi4 = 0, i;

  bol_top u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .aux_in(aux_in), .aux_out(aux_out),
    .aux_oe(aux_oe), .fast_pulse_output(fast_pulse_output),
    .rail_enable(rail_enable), .rail_status(rail_status),
    .pin_state(pin_state)
  );
  bol_load_model u_load (
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .aux_out(aux_out),
    .aux_oe(aux_oe), .ext(ext), .aux_ext(4'hF), .gpio_in(gpio_in),
    .aux_in(aux_in)
  );

  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, r, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // Strobes stay up; callers finish a burst with idle
  task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
    q.push_back({x & m, m});
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h0, 32'h0);
  endtask
  task automatic slot(input int s, input logic [31:0] c, t0, r0, t1, r1);
    logic [7:0] b;
    b = 8'(8'h40 + 8 * s);
    wr(b, c);
    wr(b + 8'h1, t0);
    wr(b + 8'h2, r0);
    wr(b + 8'h3, t1);
    wr(b + 8'h4, r1);
    // Two ticks: the first may fall at any phase, so one alone is too short
    wr(b + 8'h5, 32'h2);
    wr(b + 8'h6, 32'h2);
  endtask
  task automatic end_of_test;
    for (int k = 0; k < 20 && q.size() > 0; k++) @(posedge mclk);
    if (q.size() > 0) miscompares++;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, stimulus noise and result watcher
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 3'h1;
    if (cyc == 3'h0) fast_pulse_output <= 26'($random(seed));
    if (cnt_en) begin
      hi3 <= hi3 + 32'(pin_state[3]);
      hi4 <= hi4 + 32'(pin_state[4]);
    end
    if (rd_d && q.size() > 0) begin
      e = q.pop_front();
      chk(reg_rdata & e[31:0], e[63:32]);
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, rd_d, cnt_en} = 5'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    ext = 22'h3F3FFF;
    cyc = 3'h0;
    rail_enable = 12'h0;
    rail_status = '0;
    fast_pulse_output = 26'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(bol_pkg::CFG_ERR, 32'h0, 32'h1);
    rd(bol_pkg::PIN_BASE, 32'h0, 32'h1F);
    for (i = 0; i < 12; i++) wr(8'(i), 32'h2);
    rd(bol_pkg::CFG_ERR, 32'h0, 32'h1);
    wr(8'h0C, 32'h2);
    rd(bol_pkg::CFG_ERR, 32'h1, 32'h1);
    rd(8'h0C, 32'h0, 32'h7);
    wr(bol_pkg::CFG_ERR, 32'h1);
    wr(8'h16, 32'h2);
    rd(bol_pkg::CFG_ERR, 32'h1, 32'h1);
    wr(bol_pkg::CFG_ERR, 32'h1);
    wr(8'h16, 32'h4);
    wr(8'h0E, 32'h11);
    wr(8'h0F, 32'h01);
    rd(bol_pkg::CFG_ERR, 32'h0, 32'h1);
    wr(bol_pkg::CLR_SEL, 32'h7);
    rd(bol_pkg::CLR_SEL, 32'h7, 32'h27);
    wr(8'hB0, 32'hFFFFFFFF);
    rd(8'hB0, 32'h0, 32'hFFFFFFFF);
    slot(0, 32'hA0, 32'h0, 32'h0, 32'h0, 32'h0);
    slot(1, 32'h41, 32'h100, 32'h0, 32'h30000, 32'h4);
    slot(2, 32'h42, 32'h250000, 32'h1, 32'h0, 32'h0);
    slot(3, 32'h343, 32'h100, 32'h0, 32'h0, 32'h0);
    slot(4, 32'h744, 32'h100, 32'h0, 32'h0, 32'h0);
    slot(5, 32'h845, 32'h100, 32'h0, 32'h0, 32'h2);
    slot(6, 32'h2066, 32'h0, 32'h0, 32'h0, 32'h0);
    idle(20);
    // A pulse far shorter than one delay tick
    cnt_en <= 1'b1;
    ext[14] <= 1'b1;
    idle(50);
    ext[14] <= 1'b0;
    idle(1200);
    cnt_en <= 1'b0;
    chk(32'(hi3), 32'h0);
    chk(32'(hi4 >= bol_pkg::TICK_CYC), 32'h1);
    for (i = 0; i < 5; i++) begin
      st = stp[i];
      ext[15:14] <= {2{st[4]}};
      rail_status[0][1] <= st[3];
      rail_status[3][2] <= st[2];
      rail_enable[2] <= st[2];
      idle(12);
      rd(bol_pkg::PIN_STAT, 32'({~st[4], st[4], 7'h0, st[2], st[0],
         3'h0, st[1], 1'b1}), 32'hC063);
      idle(1);
    end
    rail_status[5][0] <= 1'b1;
    idle(1);
    rail_status[5][0] <= 1'b0;
    idle(30);
    rd(bol_pkg::PIN_STAT, 32'h4, 32'h4);
    rd(bol_pkg::RESULT, 32'h0050_0004, 32'h00F0_000F);
    wr(bol_pkg::LATCH_CLR, 32'h1);
    idle(12);
    rd(bol_pkg::PIN_STAT, 32'h0, 32'h4);
    // Clearing through the first general input
    wr(bol_pkg::CLR_SEL, 32'h20);
    rail_status[5][0] <= 1'b1;
    idle(1);
    rail_status[5][0] <= 1'b0;
    idle(8);
    rd(bol_pkg::PIN_STAT, 32'h4, 32'h4);
    ext[14] <= 1'b1;
    idle(4);
    ext[14] <= 1'b0;
    idle(12);
    rd(bol_pkg::PIN_STAT, 32'h0, 32'h4);
    // Open-drain pin 11 owned by slot 7 under host control
    wr(8'h0B, 32'h0A);
    wr(8'h78, 32'h2B);
    idle(4);
    chk(32'({gpio_oe[11], gpio_out[11]}), 32'h2);
    wr(8'h78, 32'hAB);
    idle(4);
    chk(32'({gpio_oe[11], gpio_out[11]}), 32'h0);
    idle(10);
    end_of_test();
  end
endmodule

`default_nettype wire
